// ### logic/asp_regs.svh
// Register offsets, field positions, reset values and counts of the serial port core
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
`define ASP_A_DATA    3'h0
`define ASP_A_IER     3'h1
`define ASP_A_ISR     3'h2
`define ASP_A_LCR     3'h3
`define ASP_A_MCR     3'h4
`define ASP_A_LSR     3'h5
`define ASP_A_MSR     3'h6
`define ASP_A_SPR     3'h7
`define ASP_LCR_DLAB  7
`define ASP_LCR_BRK   6
`define ASP_LCR_STICK 5
`define ASP_LCR_EVEN  4
`define ASP_LCR_PEN   3
`define ASP_LCR_STOP2 2
`define ASP_IER_RXD   0
`define ASP_IER_THRE  1
`define ASP_IER_LINE  2
`define ASP_IER_MODEM 3
`define ASP_IER_SPEC  5
`define ASP_MCR_DTR   0
`define ASP_MCR_RTS   1
`define ASP_MCR_SOFT  2
`define ASP_MCR_OUT2  3
`define ASP_MCR_LOOP  4
`define ASP_MCR_PD    7
`define ASP_DIV_RST   16'h0001
`define ASP_REG_RST   8'h00
`define ASP_TICK_LAST 4'hF
`define ASP_TICK_MID  4'h7
`define ASP_ISR_NONE  4'h1
`define ASP_ISR_LINE  4'h6
`define ASP_ISR_RXD   4'h4
`define ASP_ISR_THRE  4'h2
`define ASP_ISR_MODEM 4'h0
`define ASP_H_CMD     4'h0
`define ASP_H_STAT    4'h4
`define ASP_H_LINE    4'h8
`define ASP_LINE_RST  6'h3D
`endif

// ### logic/asp_pkg.sv
// Types shared by both ends of the serial port core
package asp_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_st_t;
  typedef enum logic [1:0] {H_IDLE, H_STROBE, H_CAPT} asp_hst_t;
endpackage : asp_pkg

// ### logic/asp_if.sv
// Register port, serial lines and modem pins between controller and serial port core
`timescale 1ns/10ps
`default_nettype none
interface asp_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       hw_reset;
  logic       reset_out;
  logic       irq;
  logic       rx;
  logic       tx;
  logic       rts_n;
  logic       dtr_n;
  logic       cts_n;
  logic       dsr_n;
  logic       carrier_detect_n;
  logic       ring_indicate_n;
  modport dev  (input addr, wdata, wr, rd, hw_reset, rx, cts_n, dsr_n, carrier_detect_n,
                ring_indicate_n, output rdata, reset_out, irq, tx, rts_n, dtr_n);
  modport host (output addr, wdata, wr, rd, hw_reset, rx, cts_n, dsr_n, carrier_detect_n,
                ring_indicate_n, input rdata, reset_out, irq, tx, rts_n, dtr_n);
endinterface : asp_if
`default_nettype wire

// ### logic/asp_baud.sv
// Baud generator: one sampling tick every divisor clocks
`timescale 1ns/10ps
`default_nettype none
module asp_baud #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] divisor,
  output logic              tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  always_comb
  begin
    cnt_d  = cnt_q + 1'b1;
    tick_d = 1'b0;
    if (!run)
    begin
      cnt_d = '0;
    end
    else if (cnt_q + 1'b1 >= divisor)
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule : asp_baud
`default_nettype wire

// ### logic/asp_dev.sv
// Serial port core: registers, transmitter, receiver, loopback and enhanced controls
// Notes on behaviour
// - Divisor makes sixteen-times sampling tick
// - Host programs divisor at initialisation
// - Divisor equals clock over sixteen times rate
// - Divisor split into upper and lower bytes
// - Byte holding and shift registers each way
// - Each transmitted bit lasts sixteen ticks
// - Start, data, optional parity, stop bits
// - Least significant data bit goes first
// - Holding empty set when byte moves on
// - Holding empty interrupt when enabled
// - Fully empty when both registers empty
// - Start bit checked low after eight ticks
// - Remaining bits sampled at their centre
// - Error tags follow byte in holding register
// - Receive ready interrupt when enabled
// - Special mode gates enhanced controls
// - Soft reset ORed onto reset output
// - Power down keeps register contents
// - Loopback feeds shifter output to receiver
// - Loopback: line mark, outputs off, inputs ignored
// - Transmit line held high during loopback
// - Divisor bytes visible only with latch bit
// - Reset output follows hardware reset otherwise
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "asp_regs.svh"
`default_nettype none
module asp_dev (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      power_down,
  asp_if.dev        bus
);
  logic [7:0]          lcr_q, lcr_d, ier_q, ier_d, mcr_q, mcr_d, spr_q, spr_d;
  logic [7:0]          dll_q, dll_d, dlm_q, dlm_d, rdata_d;
  logic [3:0]          mdm_q, mdm_d, dlt_q, dlt_d, mdm_now, interrupt_status;
  logic                thre_pend_q, thre_pend_d, tx_pin_d, rts_n_d, dtr_n_d, rst_o_d;
  logic                irq_d, pd_d;
  logic [7:0]          thr_q, thr_d, tsr_q, tsr_d;
  logic                thr_full_q, thr_full_d, tx_line_q, tx_line_d, tx_par_q, tx_par_d;
  logic [3:0]          tx_cnt_q, tx_cnt_d;
  logic [2:0]          tx_bit_q, tx_bit_d;
  asp_pkg::asp_tx_st_t tx_st_q, tx_st_d;
  logic                tx_load;
  logic [7:0]          rx_sh_q, rx_sh_d, rhr_q, rhr_d;
  logic [3:0]          rx_cnt_q, rx_cnt_d;
  logic [2:0]          rx_bit_q, rx_bit_d, err_q, err_d;
  logic                rx_prev_q, rx_prev_d, rx_pb_q, rx_pb_d, dr_q, dr_d, oe_q, oe_d;
  asp_pkg::asp_rx_st_t rx_st_q, rx_st_d;
  logic                tick, dev_rst_n, dlab, loop, spec, serial, rx_in;
  logic                rd_rhr, rd_lsr, rd_isr, rd_msr, wr_thr;
  logic [7:0]          line_status, rx_data;
  logic [2:0]          nlast;

  function automatic logic [7:0] wl_mask(input logic [1:0] wl);
    wl_mask = 8'hFF >> (2'h3 - wl);
  endfunction : wl_mask

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_control);
    logic odd;
    odd = ^(d & wl_mask(line_control[1:0]));
    if (line_control[`ASP_LCR_STICK])
      par_bit = ~line_control[`ASP_LCR_EVEN];
    else
      par_bit = line_control[`ASP_LCR_EVEN] ? odd : ~odd;
  endfunction : par_bit

  // Hardware reset pin resets everything; it comes from a flop so it cannot glitch
  assign dev_rst_n = rst_n & ~bus.hw_reset;
  assign dlab      = lcr_q[`ASP_LCR_DLAB];
  assign loop      = mcr_q[`ASP_MCR_LOOP];
  assign spec      = ier_q[`ASP_IER_SPEC];
  assign nlast     = {1'b1, lcr_q[1:0]};
  assign serial    = lcr_q[`ASP_LCR_BRK] ? 1'b0 : tx_line_q;
  assign rx_in     = loop ? serial : bus.rx;
  assign rd_rhr    = bus.rd && bus.addr == `ASP_A_DATA && !dlab;
  assign rd_isr    = bus.rd && bus.addr == `ASP_A_ISR;
  assign rd_lsr    = bus.rd && bus.addr == `ASP_A_LSR;
  assign rd_msr    = bus.rd && bus.addr == `ASP_A_MSR;
  assign wr_thr    = bus.wr && bus.addr == `ASP_A_DATA && !dlab;
  assign line_status       = {1'b0, !thr_full_q && tx_st_q == asp_pkg::TX_IDLE,
                      !thr_full_q, err_q, oe_q, dr_q};
  assign rx_data   = rx_sh_q >> (2'h3 - lcr_q[1:0]);

  // Sampling ticks stop in power down; all register contents stay
  asp_baud #(.W(16)) u_baud (
    .core_clk (core_clk),
    .rst_n    (dev_rst_n),
    .run      (!pd_d),
    .divisor  ({dlm_q, dll_q}),
    .tick     (tick)
  );

  always_comb
  begin
    mdm_now = loop ? {mcr_q[`ASP_MCR_OUT2], mcr_q[`ASP_MCR_SOFT], mcr_q[`ASP_MCR_DTR],
                      mcr_q[`ASP_MCR_RTS]}
                   : ~{bus.carrier_detect_n, bus.ring_indicate_n, bus.dsr_n, bus.cts_n};
    if (ier_q[`ASP_IER_LINE] && |line_status[4:1])
      interrupt_status = `ASP_ISR_LINE;
    else if (ier_q[`ASP_IER_RXD] && dr_q)
      interrupt_status = `ASP_ISR_RXD;
    else if (ier_q[`ASP_IER_THRE] && thre_pend_q)
      interrupt_status = `ASP_ISR_THRE;
    else if (ier_q[`ASP_IER_MODEM] && |dlt_q)
      interrupt_status = `ASP_ISR_MODEM;
    else
      interrupt_status = `ASP_ISR_NONE;
    lcr_d = lcr_q;
    ier_d = ier_q;
    mcr_d = mcr_q;
    spr_d = spr_q;
    dll_d = dll_q;
    dlm_d = dlm_q;
    mdm_d = mdm_now;
    dlt_d = rd_msr ? 4'h0 : dlt_q;
    // Change flags: a change in the read cycle is kept
    dlt_d = dlt_d | {mdm_now[3] ^ mdm_q[3], mdm_q[2] & ~mdm_now[2], mdm_now[1:0] ^ mdm_q[1:0]};
    thre_pend_d = (wr_thr || (rd_isr && interrupt_status == `ASP_ISR_THRE)) ? 1'b0 : thre_pend_q;
    if (tx_load)
      thre_pend_d = 1'b1;
    if (bus.wr)
    begin
      if (bus.addr == `ASP_A_DATA && dlab)
        dll_d = bus.wdata;
      else if (bus.addr == `ASP_A_IER && dlab)
        dlm_d = bus.wdata;
      else if (bus.addr == `ASP_A_IER)
        ier_d = bus.wdata & 8'h2F;
      else if (bus.addr == `ASP_A_LCR)
        lcr_d = bus.wdata;
      else if (bus.addr == `ASP_A_MCR)
        mcr_d = bus.wdata & 8'h9F;
      else if (bus.addr == `ASP_A_SPR)
        spr_d = bus.wdata;
    end
    rdata_d = bus.rdata;
    if (bus.rd)
    begin
      if (bus.addr == `ASP_A_DATA)
        rdata_d = dlab ? dll_q : rhr_q;
      else if (bus.addr == `ASP_A_IER)
        rdata_d = dlab ? dlm_q : ier_q;
      else if (bus.addr == `ASP_A_ISR)
        rdata_d = {4'h0, interrupt_status};
      else if (bus.addr == `ASP_A_LCR)
        rdata_d = lcr_q;
      else if (bus.addr == `ASP_A_MCR)
        rdata_d = mcr_q;
      else if (bus.addr == `ASP_A_LSR)
        rdata_d = line_status;
      else if (bus.addr == `ASP_A_MSR)
        rdata_d = {mdm_q, dlt_q};
      else
        rdata_d = spr_q;
    end
    tx_pin_d = loop ? 1'b1 : serial;
    rts_n_d  = loop ? 1'b1 : ~mcr_q[`ASP_MCR_RTS];
    dtr_n_d  = loop ? 1'b1 : ~mcr_q[`ASP_MCR_DTR];
    rst_o_d  = bus.hw_reset | (spec & mcr_q[`ASP_MCR_SOFT]);
    pd_d     = spec & mcr_q[`ASP_MCR_PD];
    irq_d    = interrupt_status != `ASP_ISR_NONE && (mcr_q[`ASP_MCR_OUT2] || !spec);
  end

  always_ff @(posedge core_clk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
    begin
      lcr_q         <= `ASP_REG_RST;
      ier_q         <= `ASP_REG_RST;
      mcr_q         <= `ASP_REG_RST;
      spr_q         <= `ASP_REG_RST;
      dll_q         <= 8'(`ASP_DIV_RST);
      dlm_q         <= 8'(`ASP_DIV_RST >> 8);
      mdm_q         <= 4'h0;
      dlt_q         <= 4'h0;
      thre_pend_q   <= 1'b0;
      bus.rdata     <= 8'h00;
      bus.tx        <= 1'b1;
      bus.rts_n     <= 1'b1;
      bus.dtr_n     <= 1'b1;
      bus.reset_out <= 1'b1;
      bus.irq       <= 1'b0;
      power_down    <= 1'b0;
    end
    else
    begin
      lcr_q         <= lcr_d;
      ier_q         <= ier_d;
      mcr_q         <= mcr_d;
      spr_q         <= spr_d;
      dll_q         <= dll_d;
      dlm_q         <= dlm_d;
      mdm_q         <= mdm_d;
      dlt_q         <= dlt_d;
      thre_pend_q   <= thre_pend_d;
      bus.rdata     <= rdata_d;
      bus.tx        <= tx_pin_d;
      bus.rts_n     <= rts_n_d;
      bus.dtr_n     <= dtr_n_d;
      bus.reset_out <= rst_o_d;
      bus.irq       <= irq_d;
      power_down    <= pd_d;
    end
  end

  always_comb
  begin
    thr_d      = wr_thr ? bus.wdata : thr_q;
    thr_full_d = thr_full_q;
    tsr_d      = tsr_q;
    tx_line_d  = tx_line_q;
    tx_par_d   = tx_par_q;
    tx_cnt_d   = tick ? tx_cnt_q + 4'h1 : tx_cnt_q;
    tx_bit_d   = tx_bit_q;
    tx_st_d    = tx_st_q;
    tx_load    = 1'b0;
    case (tx_st_q)
      asp_pkg::TX_IDLE:
        // Load on a tick so the start bit lasts sixteen full ticks
        if (thr_full_q && tick)
        begin
          tx_load    = 1'b1;
          thr_full_d = 1'b0;
          tsr_d      = thr_q;
          tx_par_d   = par_bit(thr_q, lcr_q);
          tx_line_d  = 1'b0;
          tx_cnt_d   = 4'h0;
          tx_st_d    = asp_pkg::TX_START;
        end
      asp_pkg::TX_START:
        if (tick && tx_cnt_q == `ASP_TICK_LAST)
        begin
          tx_line_d = tsr_q[0];
          tx_bit_d  = 3'h0;
          tx_st_d   = asp_pkg::TX_DATA;
        end
      asp_pkg::TX_DATA:
        if (tick && tx_cnt_q == `ASP_TICK_LAST)
        begin
          tsr_d    = tsr_q >> 1;
          tx_bit_d = tx_bit_q + 3'h1;
          if (tx_bit_q != nlast)
            tx_line_d = tsr_q[1];
          else if (lcr_q[`ASP_LCR_PEN])
          begin
            tx_line_d = tx_par_q;
            tx_st_d   = asp_pkg::TX_PAR;
          end
          else
          begin
            tx_line_d = 1'b1;
            tx_bit_d  = 3'h0;
            tx_st_d   = asp_pkg::TX_STOP;
          end
        end
      asp_pkg::TX_PAR:
        if (tick && tx_cnt_q == `ASP_TICK_LAST)
        begin
          tx_line_d = 1'b1;
          tx_bit_d  = 3'h0;
          tx_st_d   = asp_pkg::TX_STOP;
        end
      default:
        if (tick && tx_cnt_q == `ASP_TICK_LAST)
        begin
          tx_bit_d = 3'h1;
          if (!lcr_q[`ASP_LCR_STOP2] || tx_bit_q != 3'h0)
            tx_st_d = asp_pkg::TX_IDLE;
        end
    endcase
    if (wr_thr)
      thr_full_d = 1'b1;
  end

  always_ff @(posedge core_clk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
    begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
      tsr_q      <= 8'h00;
      tx_line_q  <= 1'b1;
      tx_par_q   <= 1'b0;
      tx_cnt_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_st_q    <= asp_pkg::TX_IDLE;
    end
    else
    begin
      thr_q      <= thr_d;
      thr_full_q <= thr_full_d;
      tsr_q      <= tsr_d;
      tx_line_q  <= tx_line_d;
      tx_par_q   <= tx_par_d;
      tx_cnt_q   <= tx_cnt_d;
      tx_bit_q   <= tx_bit_d;
      tx_st_q    <= tx_st_d;
    end
  end

  always_comb
  begin
    rx_prev_d = rx_in;
    rx_sh_d   = rx_sh_q;
    rx_pb_d   = rx_pb_q;
    rx_cnt_d  = tick ? rx_cnt_q + 4'h1 : rx_cnt_q;
    rx_bit_d  = rx_bit_q;
    rx_st_d   = rx_st_q;
    rhr_d     = rhr_q;
    dr_d      = rd_rhr ? 1'b0 : dr_q;
    err_d     = rd_rhr ? 3'h0 : err_q;
    oe_d      = rd_lsr ? 1'b0 : oe_q;
    case (rx_st_q)
      asp_pkg::RX_IDLE:
        if (rx_prev_q && !rx_in)
        begin
          rx_cnt_d = 4'h0;
          rx_st_d  = asp_pkg::RX_START;
        end
      asp_pkg::RX_START:
        if (tick && rx_cnt_q == `ASP_TICK_MID)
        begin
          rx_cnt_d = 4'h0;
          rx_bit_d = 3'h0;
          rx_st_d  = rx_in ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
        end
      asp_pkg::RX_DATA:
        if (tick && rx_cnt_q == `ASP_TICK_LAST)
        begin
          rx_sh_d  = {rx_in, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == nlast)
            rx_st_d = lcr_q[`ASP_LCR_PEN] ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
        end
      asp_pkg::RX_PAR:
        if (tick && rx_cnt_q == `ASP_TICK_LAST)
        begin
          rx_pb_d = rx_in;
          rx_st_d = asp_pkg::RX_STOP;
        end
      default:
        if (tick && rx_cnt_q == `ASP_TICK_LAST)
        begin
          rhr_d   = rx_data;
          dr_d    = 1'b1;
          oe_d    = oe_d | (dr_q && !rd_rhr);
          err_d   = {~rx_in && rx_data == 8'h00 && !(lcr_q[`ASP_LCR_PEN] && rx_pb_q),
                     ~rx_in,
                     lcr_q[`ASP_LCR_PEN] && rx_pb_q != par_bit(rx_data, lcr_q)};
          rx_st_d = asp_pkg::RX_IDLE;
        end
    endcase
  end

  always_ff @(posedge core_clk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
    begin
      rx_prev_q <= 1'b1;
      rx_sh_q   <= 8'h00;
      rx_pb_q   <= 1'b0;
      rx_cnt_q  <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_st_q   <= asp_pkg::RX_IDLE;
      rhr_q     <= 8'h00;
      dr_q      <= 1'b0;
      err_q     <= 3'h0;
      oe_q      <= 1'b0;
    end
    else
    begin
      rx_prev_q <= rx_prev_d;
      rx_sh_q   <= rx_sh_d;
      rx_pb_q   <= rx_pb_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_st_q   <= rx_st_d;
      rhr_q     <= rhr_d;
      dr_q      <= dr_d;
      err_q     <= err_d;
      oe_q      <= oe_d;
    end
  end
endmodule : asp_dev
`default_nettype wire

// ### logic/asp_host.sv
// Controller: Wishbone slave that drives the serial port core's register port and pins
`timescale 1ns/10ps
`include "asp_regs.svh"
`default_nettype none
module asp_host (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  asp_if.host              bus
);
  asp_pkg::asp_hst_t st_q, st_d;
  logic [11:0]       cmd_q, cmd_d;
  logic [7:0]        res_q, res_d;
  logic [5:0]        line_q, line_d;
  logic [31:0]       dat_d;
  logic              ack_d, req;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Software sets the divisor (clock over sixteen times rate) through CMD writes
  always_comb
  begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    res_d  = res_q;
    line_d = line_q;
    ack_d  = req;
    dat_d  = wb_dat_o;
    if (req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == `ASP_H_CMD && st_q == asp_pkg::H_IDLE && wb_sel_i[1])
      begin
        cmd_d = wb_dat_i[11:0];
        st_d  = asp_pkg::H_STROBE;
      end
      else if (wb_adr_i == `ASP_H_LINE)
        line_d = wb_dat_i[5:0];
    end
    if (req && !wb_we_i)
    begin
      if (wb_adr_i == `ASP_H_STAT)
        dat_d = {23'h0, st_q != asp_pkg::H_IDLE, res_q};
      else if (wb_adr_i == `ASP_H_LINE)
        dat_d = {19'h0, bus.irq, bus.reset_out, bus.dtr_n, bus.rts_n, bus.tx, 2'h0, line_q};
      else
        dat_d = {20'h0, cmd_q};
    end
    case (st_q)
      asp_pkg::H_STROBE:
        st_d = asp_pkg::H_CAPT;
      asp_pkg::H_CAPT:
      begin
        res_d = bus.rdata;
        st_d  = asp_pkg::H_IDLE;
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q                 <= asp_pkg::H_IDLE;
      cmd_q                <= 12'h000;
      res_q                <= 8'h00;
      line_q               <= `ASP_LINE_RST;
      wb_dat_o             <= 32'h0000_0000;
      wb_ack_o             <= 1'b0;
      bus.addr             <= 3'h0;
      bus.wdata            <= 8'h00;
      bus.wr               <= 1'b0;
      bus.rd               <= 1'b0;
      bus.rx               <= 1'b1;
      bus.hw_reset         <= 1'b0;
      bus.cts_n            <= 1'b1;
      bus.dsr_n            <= 1'b1;
      bus.carrier_detect_n <= 1'b1;
      bus.ring_indicate_n  <= 1'b1;
    end
    else
    begin
      st_q                 <= st_d;
      cmd_q                <= cmd_d;
      res_q                <= res_d;
      line_q               <= line_d;
      wb_dat_o             <= dat_d;
      wb_ack_o             <= ack_d;
      bus.addr             <= cmd_d[10:8];
      bus.wdata            <= cmd_d[7:0];
      bus.wr               <= st_d == asp_pkg::H_STROBE && cmd_d[11];
      bus.rd               <= st_d == asp_pkg::H_STROBE && !cmd_d[11];
      bus.rx               <= line_d[0];
      bus.hw_reset         <= line_d[1];
      bus.cts_n            <= line_d[2];
      bus.dsr_n            <= line_d[3];
      bus.carrier_detect_n <= line_d[4];
      bus.ring_indicate_n  <= line_d[5];
    end
  end
endmodule : asp_host
`default_nettype wire

// ### sim/asp_checker.sv
// Checker on the link between controller and serial core
`timescale 1ns/10ps
`default_nettype none
`include "asp_regs.svh"
module asp_checker #(
  parameter int DIV = 2
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       hw_reset,
  input wire logic       reset_out,
  input wire logic       irq,
  input wire logic       tx,
  input wire logic       rts_n,
  input wire logic       dtr_n,
  input wire logic       power_down
);
  localparam int BIT = 16 * DIV;
  typedef struct packed {
    logic [7:0]  interrupt_enable;
    logic [7:0]  modem_control;
    logic [15:0] dvs;
    logic        dlab;
    logic [15:0] cnt;
    logic        txl;
  } asp_shd_t;
  localparam asp_shd_t SHD_RST = '{8'h00, 8'h00, 16'h0001, 1'b0, 16'h0000, 1'b1};
  asp_shd_t s_q;
  asp_shd_t s_d;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Shadow of the core's controls; the hardware reset clears it one edge late
  always_comb
  begin
    s_d = hw_reset ? SHD_RST : s_q;
    s_d.cnt = (s_q.txl && !tx) ? 16'h0001 : s_q.cnt + 16'h0001;
    s_d.txl = tx;
    if (wr && !hw_reset)
    begin
      if (addr == `ASP_A_LCR) s_d.dlab = wdata[7];
      if (addr == `ASP_A_MCR) s_d.modem_control = wdata;
      if (addr == `ASP_A_IER && !s_q.dlab) s_d.interrupt_enable = wdata;
      if (addr == `ASP_A_IER && s_q.dlab) s_d.dvs[15:8] = wdata;
      if (addr == `ASP_A_DATA && s_q.dlab) s_d.dvs[7:0] = wdata;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      s_q <= SHD_RST;
    else
      s_q <= s_d;
  property p_rst_follow;
    $past(rst_n) && !hw_reset |-> reset_out == $past(hw_reset || (s_q.interrupt_enable[5] && s_q.modem_control[2]));
  endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("reset output wrong");
  property p_hw_out;
    hw_reset |-> reset_out;
  endproperty
  a_hw_out: assert property (p_hw_out) else $error("reset output low in reset");
  property p_loop_pins;
    s_q.modem_control[4] && $past(s_q.modem_control[4]) |-> tx && rts_n && dtr_n;
  endproperty
  a_loop_pins: assert property (p_loop_pins) else $error("pins active in loopback");
  // Idle gaps are free, so only rising edges are measured from the last fall
  property p_bit_time;
    $rose(tx) && s_q.dvs == DIV && !s_q.modem_control[4] && !$past(s_q.modem_control[4]) |-> s_q.cnt % BIT == 0;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit time wrong");
  property p_rdata_hold;
    !rd && !hw_reset |=> $stable(rdata) || hw_reset;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_irq_gate;
    s_q.interrupt_enable[3:0] == 4'h0 && $past(s_q.interrupt_enable[3:0]) == 4'h0 |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not enabled");
  property p_modem_out;
    !hw_reset && !s_q.modem_control[4] && $stable(s_q.modem_control) |-> rts_n == !s_q.modem_control[1] && dtr_n == !s_q.modem_control[0];
  endproperty
  a_modem_out: assert property (p_modem_out) else $error("modem outputs wrong");
  property p_pd_level;
    $past(rst_n) && !hw_reset && $stable(s_q.interrupt_enable[5] && s_q.modem_control[7])
      |-> power_down == (s_q.interrupt_enable[5] && s_q.modem_control[7]);
  endproperty
  a_pd_level: assert property (p_pd_level) else $error("power down level wrong");
  c_tx_frame: cover property ($rose(tx));
  c_loop_rd: cover property (s_q.modem_control[4] && rd);
  c_soft_rst: cover property (reset_out && !hw_reset);
endmodule : asp_checker
`default_nettype wire

// ### sim/async_serial_port_core_tb.sv
// Testbench joining controller and serial core, checking registers and the wire
`timescale 1ns/10ps
`default_nettype none
`include "asp_regs.svh"
module async_serial_port_core_tb;
  localparam int DIV = 2;
  localparam int BIT = 16 * DIV;
  logic        core_clk, rst_n, cyc, stb, we, want, wb_ack_o, power_down;
  logic [3:0]  adr;
  logic [31:0] dat, rdat, wb_dat_o;
  logic [7:0]  b, seed;
  logic [10:0] f;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  logic [10:0] frm_q[$];
  int          fails, total_checks, cycles;
  asp_if bus ();
  asp_host u_asp_host (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus(bus));
  asp_dev u_asp_dev (.core_clk(core_clk), .rst_n(rst_n), .power_down(power_down), .bus(bus));
  asp_checker #(.DIV(DIV)) u_asp_checker (.core_clk(core_clk), .rst_n(rst_n), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .hw_reset(bus.hw_reset),
    .reset_out(bus.reset_out), .irq(bus.irq), .tx(bus.tx), .rts_n(bus.rts_n),
    .dtr_n(bus.dtr_n), .power_down(power_down));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    total_checks++;
    if (seen !== expd)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // One classic cycle; a checked read leaves its expectation in the queue
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c,
                    input logic [31:0] m);
    if (c)
      exp_q.push_back({m, d});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    want <= c;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    want <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic dev(input logic w, input logic [2:0] a, input logic [7:0] d);
    wb(1'b1, 4'h0, {20'h0, w, a, d}, 1'b0, 32'h0);
    rdat = 32'h100;
    for (int i = 0; i < 20 && rdat[8] !== 1'b0; i++)
      wb(1'b0, 4'h4, 32'h0, 1'b0, 32'h0);
  endtask : dev
  task automatic chk(input logic [2:0] a, input logic [7:0] x);
    dev(1'b0, a, 8'h00);
    wb(1'b0, 4'h4, {24'h0, x}, 1'b1, 32'hFF);
  endtask : chk
  task automatic line(input logic [5:0] v);
    wb(1'b1, 4'h8, {26'h0, v}, 1'b0, 32'h0);
  endtask : line
  always @(negedge core_clk)
    if (want && wb_ack_o === 1'b1)
    begin
      e = exp_q.pop_front();
      check(wb_dat_o & e[63:32], e[31:0]);
    end
  // Mid-bit sampling keeps clear of the edges where the line changes
  initial
  begin
    forever
    begin
      @(negedge bus.tx);
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 11; i++)
      begin
        f[i] = bus.tx;
        repeat (BIT) @(posedge core_clk);
      end
      check(f, frm_q.pop_front());
    end
  end
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    {cyc, stb, we, want, adr, dat} = '0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    seed = 8'h1F;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    line(6'h3D);
    chk(`ASP_A_LSR, 8'h60);
    dev(1'b1, `ASP_A_LCR, 8'h80);
    chk(`ASP_A_DATA, 8'h01);
    dev(1'b1, `ASP_A_IER, 8'h09);
    dev(1'b1, `ASP_A_DATA, 8'(DIV));
    dev(1'b1, `ASP_A_LCR, 8'h03);
    chk(`ASP_A_IER, 8'h00);
    dev(1'b1, `ASP_A_LCR, 8'h83);
    chk(`ASP_A_IER, 8'h09);
    dev(1'b1, `ASP_A_IER, 8'h00);
    dev(1'b1, `ASP_A_LCR, 8'h1B);
    seed = lfsr(seed);
    dev(1'b1, `ASP_A_SPR, seed);
    b = lfsr(seed);
    frm_q.push_back({1'b1, ^b, b, 1'b0});
    dev(1'b1, `ASP_A_DATA, b);
    repeat (12 * BIT) @(posedge core_clk);
    chk(`ASP_A_LSR, 8'h60);
    dev(1'b1, `ASP_A_MCR, 8'h10);
    dev(1'b1, `ASP_A_IER, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      dev(1'b1, `ASP_A_LCR, {3'b000, i[0], i[1], i[0], i[1:0]});
      b = lfsr(b);
      dev(1'b1, `ASP_A_DATA, b);
      chk(`ASP_A_LSR, 8'h20);
      chk(`ASP_A_ISR, 8'h02);
      repeat (13 * BIT) @(posedge core_clk);
      chk(`ASP_A_LSR, 8'h61);
      chk(`ASP_A_ISR, 8'h04);
      wb(1'b0, 4'h8, 32'h1000, 1'b1, 32'h1000);
      chk(`ASP_A_DATA, b & (8'hFF >> (3 - i)));
    end
    dev(1'b1, `ASP_A_MCR, 8'h00);
    dev(1'b1, `ASP_A_IER, 8'h00);
    dev(1'b1, `ASP_A_LCR, 8'h03);
    // A three-cycle dip is far shorter than the half-bit check
    line(6'h3C);
    line(6'h3D);
    repeat (12 * BIT) @(posedge core_clk);
    chk(`ASP_A_LSR, 8'h60);
    f = {2'b00, 8'hA5, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line({5'b11110, f[i]});
      repeat (BIT - 3) @(posedge core_clk);
    end
    line(6'h3D);
    chk(`ASP_A_LSR, 8'h69);
    chk(`ASP_A_DATA, 8'hA5);
    chk(`ASP_A_LSR, 8'h60);
    dev(1'b1, `ASP_A_MCR, 8'h84);
    wb(1'b0, 4'h8, 32'h0, 1'b1, 32'h800);
    check(power_down, 1'b0);
    dev(1'b1, `ASP_A_IER, 8'h20);
    wb(1'b0, 4'h8, 32'h800, 1'b1, 32'h800);
    check(power_down, 1'b1);
    chk(`ASP_A_SPR, seed);
    dev(1'b1, `ASP_A_MCR, 8'h00);
    line(6'h3F);
    wb(1'b0, 4'h8, 32'h800, 1'b1, 32'h800);
    line(6'h3D);
    chk(`ASP_A_SPR, 8'h00);
    stop_test();
  end
endmodule : async_serial_port_core_tb
`default_nettype wire
